// ===== verilog/tpo_regs.svh
// Register map, field positions, reset values and timing constants of the output unit.
`ifndef TPO_REGS_SVH
`define TPO_REGS_SVH
`define TPO_CTRL_ADDR    8'h00
`define TPO_MINW_ADDR    8'h04
`define TPO_ISTAT_ADDR   8'h08
`define TPO_ICLR_ADDR    8'h0C
`define TPO_IEN_ADDR     8'h10
`define TPO_SEL_GRP      4'h2
`define TPO_PER_GRP      4'h3
`define TPO_TAU_GRP      4'h4
`define TPO_PV_GRP       4'h5
`define TPO_CTRL_RUN     0
`define TPO_CTRL_LIN     1
`define TPO_CTRL_ONOFF   4
`define TPO_EV_REFUSED   0
`define TPO_EV_ERROR     1
`define TPO_SEL_MAX      8'h90
`define TPO_SEL_RST0     8'h2F
`define TPO_SEL_RST1     8'h4F
`define TPO_SEL_RST2     8'h6F
`define TPO_SEL_RST3     8'h8F
`define TPO_CH_BASE      8'h10
`define TPO_PER_MAX      7'h63
`define TPO_PER_RST      7'h02
`define TPO_PER_ZERO_ST  16'h00FA
`define TPO_ST_PER_SEC   16'h01F4
`define TPO_MINW_MAX     10'h1F4
`define TPO_MINW_RST     10'h00A
`define TPO_FULL         10'h3E8
`define TPO_HALF_FULL    26'h00001F4
`define TPO_TAU_MAX      14'h270F
`define TPO_ERR_MASK     16'h3FFF
`define TPO_DIV_NUM_BIT  5'h10
`define TPO_CLK_NS       5
`define TPO_RES_NS       2000000
`define TPO_FILT_NS      100000000
`define TPO_FILT_TICKS   (`TPO_FILT_NS / `TPO_RES_NS)
`endif

// ===== verilog/tpo_pkg.sv
// Types shared by the time-proportional output unit.
package tpo_pkg;
    typedef struct packed {
        logic [2:0]  alarm;
        logic        input_err;
        logic        remote_setpoint_input_err;
        logic        heater_open_alarm;
        logic        heater_short_alarm;
        logic        heater_overcurrent_alarm;
        logic [15:0] process_value;
        logic [15:0] setpoint;
        logic [9:0]  manip_heat;
        logic [9:0]  manip_cool;
    } tpo_chan_t;
    typedef enum logic [1:0] {SRC_BIN, SRC_VAL, SRC_PID} tpo_kind_t;
    typedef struct packed {
        tpo_kind_t  kind;
        logic       bin;
        logic [9:0] val;
    } tpo_src_t;
endpackage

// ===== verilog/tpo_unit.sv
// Output unit: input filters, output source routing and time-proportional pulses.
`timescale 1ns/100ps
`include "tpo_regs.svh"
module tpo_unit
    import tpo_pkg::*;
#(
    parameter int TICK_CYC = `TPO_RES_NS / `TPO_CLK_NS
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       addr,
    input  wire logic [31:0]      wdata,
    input  wire logic             wr_stb,
    input  wire logic             rd_stb,
    output logic [31:0]           rdata_ff,
    input  wire tpo_chan_t [3:0]  ch_in,
    input  wire logic [15:0]      dev_status,
    output logic [3:0]            pulse_out_ff,
    output logic [1:0][9:0]       lin_out_ff,
    output logic                  irq_ff
);
    logic              run_ff;
    logic              lin_ff;
    logic [3:0]        onoff_ff;
    logic [9:0]        minw_ff;
    logic [1:0]        istat_ff;
    logic [1:0]        ien_ff;
    logic [3:0][7:0]   sel_ff;
    logic [3:0][6:0]   per_ff;
    logic [3:0][13:0]  tau_ff;
    logic [3:0][16:0]  coef_ff;
    logic [3:0][31:0]  filt_ff;
    logic [3:0][15:0]  pos_ff;
    logic [3:0][15:0]  on_ff;
    logic [18:0]       tick_cnt_ff;
    logic              tick_ff;
    logic [5:0]        fstep_cnt_ff;
    logic              err_q_ff;
    logic [14:0]       drem_ff;
    logic [16:0]       dquo_ff;
    logic [4:0]        dbit_ff;
    logic [1:0]        dch_ff;
    logic              ctl_err;
    logic              refused;
    logic              wr_sel;
    logic [1:0]        widx;
    logic [3:0]        wgrp;
    logic [3:0][15:0]  per_steps;

    assign wgrp = addr[7:4];
    assign widx = addr[3:2];
    assign ctl_err = |(dev_status & `TPO_ERR_MASK);
    assign wr_sel = wr_stb && (wgrp == `TPO_SEL_GRP);
    assign refused = wr_stb && run_ff && ((wgrp == `TPO_SEL_GRP) || (wgrp == `TPO_PER_GRP)
                     || (addr == `TPO_MINW_ADDR));

    // Control period in 2 ms steps.
    function automatic logic [15:0] steps_of(input logic [6:0] sec);
        if (sec == 7'h00) begin
            return `TPO_PER_ZERO_ST;
        end
        return 16'(sec) * `TPO_ST_PER_SEC;
    endfunction

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            per_steps[i] = steps_of(per_ff[i]);
        end
    end

    // On time of one period in steps, with the minimum-width clamp.
    function automatic logic [15:0] on_steps(input logic [15:0] per, input logic [9:0] val,
                                             input logic [9:0] minw);
        logic [25:0] t;
        t = 26'h0;
        if (val < minw) begin
            return 16'h0000;
        end
        if (val >= `TPO_FULL - minw) begin
            return per;
        end
        t = (26'(per) * 26'(val) + `TPO_HALF_FULL) / 26'(`TPO_FULL);
        if (minw != 10'h000 && t == 26'h0) begin
            t = 26'h1;
        end
        if (minw != 10'h000 && t[15:0] == per) begin
            t = 26'(per - 16'h0001);
        end
        return t[15:0];
    endfunction

    function automatic logic [9:0] clamp_pct(input logic [15:0] v);
        if (v[15]) begin
            return 10'h000;
        end
        if (v > 16'(`TPO_FULL)) begin
            return `TPO_FULL;
        end
        return v[9:0];
    endfunction

    // Evaluates one source code; ON/OFF control turns heat and cool values binary.
    function automatic tpo_src_t src_eval(input logic [7:0] code);
        tpo_src_t   s;
        logic [7:0] rel;
        logic [1:0] c;
        logic [4:0] item;
        logic [3:0][7:0] f;
        logic [7:0] f_or;
        logic [7:0] f_and;
        s = '{kind: SRC_BIN, bin: 1'b0, val: 10'h000};
        rel = code - `TPO_CH_BASE;
        c = rel[6:5];
        item = rel[4:0];
        f_or = 8'h00;
        f_and = 8'hFF;
        for (int i = 0; i < 4; i++) begin
            f[i] = {ch_in[i].alarm, ch_in[i].input_err, ch_in[i].remote_setpoint_input_err,
                    ch_in[i].heater_open_alarm, ch_in[i].heater_short_alarm,
                    ch_in[i].heater_overcurrent_alarm};
            f_or = f_or | f[i];
            f_and = f_and & f[i];
        end
        if (code > `TPO_SEL_MAX) begin
            s.bin = 1'b0;
        end else if (code < `TPO_CH_BASE) begin
            case (code[3:0])
                4'h1: s.bin = ctl_err;
                4'h2: s.bin = |f_or;
                4'h3: s.bin = &f_and;
                4'h4: s.bin = |f_or[7:5];
                4'h5: s.bin = &f_and[7:5];
                4'h6: s.bin = f_or[4];
                4'h7: s.bin = f_or[3];
                4'h8: s.bin = f_or[2];
                4'h9: s.bin = f_or[1];
                4'hA: s.bin = f_or[0];
                default: s.bin = 1'b0;
            endcase
        end else if (rel[7]) begin
            s.bin = 1'b0;
        end else begin
            case (item)
                5'h00, 5'h01, 5'h02: s.bin = f[c][3'h7 - 3'(item)];
                5'h03: s.bin = f[c][4];
                5'h04: s.bin = f[c][3];
                5'h05: s.bin = f[c][2];
                5'h06: s.bin = f[c][1];
                5'h07: s.bin = f[c][0];
                5'h08: s.bin = |f[c];
                5'h09: s.bin = &f[c];
                5'h0A: s = '{kind: SRC_VAL, bin: 1'b0, val: clamp_pct(ch_in[c].process_value)};
                5'h0B: s = '{kind: SRC_VAL, bin: 1'b0, val: clamp_pct(ch_in[c].setpoint)};
                5'h1E: s = '{kind: SRC_PID, bin: 1'b0, val: ch_in[c].manip_cool};
                5'h1F: s = '{kind: SRC_PID, bin: 1'b0, val: ch_in[c].manip_heat};
                default: s.bin = 1'b0;
            endcase
            if (s.kind == SRC_PID && onoff_ff[c]) begin
                s = '{kind: SRC_BIN, bin: (s.val != 10'h000), val: 10'h000};
            end
        end
        return s;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
            lin_ff <= 1'b0;
            onoff_ff <= 4'h0;
            minw_ff <= `TPO_MINW_RST;
            ien_ff <= 2'h0;
        end else if (wr_stb && addr == `TPO_CTRL_ADDR) begin
            run_ff <= wdata[`TPO_CTRL_RUN];
            lin_ff <= wdata[`TPO_CTRL_LIN];
            onoff_ff <= wdata[`TPO_CTRL_ONOFF +: 4];
        end else if (wr_stb && addr == `TPO_IEN_ADDR) begin
            ien_ff <= wdata[1:0];
        end else if (wr_stb && addr == `TPO_MINW_ADDR && !run_ff) begin
            minw_ff <= (wdata[9:0] > `TPO_MINW_MAX) ? `TPO_MINW_MAX : wdata[9:0];
        end
    end

    // Selectors and periods hold while running; refused writes raise an event.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff <= {`TPO_SEL_RST3, `TPO_SEL_RST2, `TPO_SEL_RST1, `TPO_SEL_RST0};
            per_ff <= {4{`TPO_PER_RST}};
            tau_ff <= '0;
        end else if (wr_stb) begin
            if (wr_sel && !run_ff) begin
                sel_ff[widx] <= wdata[7:0];
            end else if (wgrp == `TPO_PER_GRP && !run_ff) begin
                per_ff[widx] <= (wdata[6:0] > `TPO_PER_MAX) ? `TPO_PER_MAX : wdata[6:0];
            end else if (wgrp == `TPO_TAU_GRP) begin
                tau_ff[widx] <= (wdata[13:0] > `TPO_TAU_MAX) ? `TPO_TAU_MAX : wdata[13:0];
            end
        end
    end

    // Sticky events; a new event beats a clear in the same cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            istat_ff <= 2'h0;
            err_q_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            err_q_ff <= ctl_err;
            istat_ff <= (istat_ff & ~((wr_stb && addr == `TPO_ICLR_ADDR) ? wdata[1:0] : 2'h0))
                        | {ctl_err && !err_q_ff, refused};
            irq_ff <= |(istat_ff & ien_ff);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0;
        end else if (!rd_stb) begin
            rdata_ff <= 32'h0;
        end else if (addr == `TPO_CTRL_ADDR) begin
            rdata_ff <= 32'({onoff_ff, 2'h0, lin_ff, run_ff});
        end else if (addr == `TPO_MINW_ADDR) begin
            rdata_ff <= 32'(minw_ff);
        end else if (addr == `TPO_ISTAT_ADDR) begin
            rdata_ff <= 32'(istat_ff);
        end else if (addr == `TPO_IEN_ADDR) begin
            rdata_ff <= 32'(ien_ff);
        end else if (wgrp == `TPO_SEL_GRP) begin
            rdata_ff <= 32'(sel_ff[widx]);
        end else if (wgrp == `TPO_PER_GRP) begin
            rdata_ff <= 32'(per_ff[widx]);
        end else if (wgrp == `TPO_TAU_GRP) begin
            rdata_ff <= 32'(tau_ff[widx]);
        end else if (wgrp == `TPO_PV_GRP) begin
            rdata_ff <= 32'(filt_ff[widx][31:16]);
        end else begin
            rdata_ff <= 32'h0;
        end
    end

    // One 2 ms tick drives both pulse timing and the 100 ms filter step.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 19'h0;
            tick_ff <= 1'b0;
            fstep_cnt_ff <= 6'h0;
        end else begin
            tick_ff <= (tick_cnt_ff == 19'(TICK_CYC - 1));
            tick_cnt_ff <= (tick_cnt_ff == 19'(TICK_CYC - 1)) ? 19'h0 : tick_cnt_ff + 19'h1;
            if (tick_ff) begin
                fstep_cnt_ff <= (fstep_cnt_ff == 6'(`TPO_FILT_TICKS - 1)) ? 6'h0
                                : fstep_cnt_ff + 6'h1;
            end
        end
    end

    // Serial divider refreshes each channel's gain 65536/(tau+1) in turn.
    // The gain may lag a tau write by up to about 84 cycles, far below one filter step.
    always_ff @(posedge core_clk or negedge rst_n) begin
        logic [15:0] r2;
        r2 = 16'h0;
        if (!rst_n) begin
            drem_ff <= 15'h0;
            dquo_ff <= 17'h0;
            dbit_ff <= 5'h0;
            dch_ff <= 2'h0;
            coef_ff <= {4{17'h10000}};
        end else begin
            r2 = {drem_ff, (dbit_ff == 5'h0)};
            if (r2 >= 16'(tau_ff[dch_ff]) + 16'h1) begin
                drem_ff <= 15'(r2 - 16'(tau_ff[dch_ff]) - 16'h1);
                dquo_ff <= {dquo_ff[15:0], 1'b1};
            end else begin
                drem_ff <= r2[14:0];
                dquo_ff <= {dquo_ff[15:0], 1'b0};
            end
            if (dbit_ff == `TPO_DIV_NUM_BIT) begin
                coef_ff[dch_ff] <= {dquo_ff[15:0], (r2 >= 16'(tau_ff[dch_ff]) + 16'h1)};
                dbit_ff <= 5'h0;
                dch_ff <= dch_ff + 2'h1;
                drem_ff <= 15'h0;
            end else begin
                dbit_ff <= dbit_ff + 5'h1;
            end
        end
    end

    // First-order filter: y += (x - y) * gain, in 16.16 fixed point.
    always_ff @(posedge core_clk or negedge rst_n) begin
        logic signed [33:0] diff;
        logic signed [51:0] prod;
        diff = '0;
        prod = '0;
        if (!rst_n) begin
            filt_ff <= '0;
        end else if (tick_ff && fstep_cnt_ff == 6'h0) begin
            for (int i = 0; i < 4; i++) begin
                diff = 34'($signed({ch_in[i].process_value, 16'h0})) - 34'($signed(filt_ff[i]));
                prod = 52'(diff) * $signed({1'b0, coef_ff[i]});
                filt_ff[i] <= filt_ff[i] + prod[47:16];
            end
        end
    end

    // Period counters; the on time is latched when a period begins.
    always_ff @(posedge core_clk or negedge rst_n) begin
        tpo_src_t s;
        s = '{kind: SRC_BIN, bin: 1'b0, val: 10'h000};
        if (!rst_n) begin
            pos_ff <= '0;
            on_ff <= '0;
        end else if (tick_ff) begin
            for (int i = 0; i < 4; i++) begin
                s = src_eval(sel_ff[i]);
                if (pos_ff[i] >= per_steps[i] - 16'h1) begin
                    pos_ff[i] <= 16'h0;
                    on_ff[i] <= on_steps(per_steps[i], s.val, minw_ff);
                end else begin
                    pos_ff[i] <= pos_ff[i] + 16'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        tpo_src_t s;
        s = '{kind: SRC_BIN, bin: 1'b0, val: 10'h000};
        if (!rst_n) begin
            pulse_out_ff <= 4'h0;
            lin_out_ff <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                s = src_eval(sel_ff[i]);
                if (s.kind == SRC_PID && !(lin_ff && i < 2)) begin
                    pulse_out_ff[i] <= (pos_ff[i] < on_ff[i]);
                end else begin
                    pulse_out_ff[i] <= s.bin;
                end
                if (i < 2) begin
                    lin_out_ff[i] <= (s.kind == SRC_BIN) ? (s.bin ? `TPO_FULL : 10'h000)
                                     : s.val;
                end
            end
        end
    end
endmodule // tpo_unit

// ===== verification/tpo_unit_chk.sv
// Concurrent checks on the ports of the output unit.
`timescale 1ns/100ps
module tpo_unit_chk
    import tpo_pkg::*;
#(
    parameter int TICK_CYC = 10
) (
    input wire logic            core_clk,
    input wire logic            rst_n,
    input wire logic [7:0]      addr,
    input wire logic [31:0]     wdata,
    input wire logic            wr_stb,
    input wire logic            rd_stb,
    input wire logic [31:0]     rdata_ff,
    input wire tpo_chan_t [3:0] ch_in,
    input wire logic [15:0]     dev_status,
    input wire logic [3:0]      pulse_out_ff,
    input wire logic [1:0][9:0] lin_out_ff,
    input wire logic            irq_ff
);
    logic [7:0]      ctrl_ff;
    logic [1:0]      ien_ff;
    logic [3:0][7:0] sel_ff;
    int              run_len_ff;

    // Shadow of the settings, so that each output's source is known here.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= 8'h00;
            ien_ff <= 2'h0;
            sel_ff <= {8'h8F, 8'h6F, 8'h4F, 8'h2F};
        end else if (wr_stb) begin
            if (addr == 8'h00) ctrl_ff <= wdata[7:0];
            if (addr == 8'h10) ien_ff <= wdata[1:0];
            if (addr[7:4] == 4'h2 && !ctrl_ff[0]) sel_ff[addr[3:2]] <= wdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) run_len_ff <= 0;
        else if (pulse_out_ff[2]) run_len_ff <= run_len_ff + 1;
        else run_len_ff <= 0;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_quiet;
        ($stable(sel_ff) && $stable(ctrl_ff) && $stable(ch_in) && $stable(dev_status))[*6];
    endsequence

    a_err_route: assert property (
        s_quiet ##0 sel_ff[3] == 8'h01 |-> pulse_out_ff[3] == |dev_status[13:0])
        else $error("controller error not routed to output four");
    a_err_event: assert property (
        ien_ff[1] && $rose(|dev_status[13:0]) |-> ##[1:4] irq_ff)
        else $error("controller error event raised no interrupt");
    a_sel_share: assert property (
        s_quiet ##0 sel_ff[0] == sel_ff[1] && sel_ff[0] inside {[8'h01:8'h0A]}
        |-> pulse_out_ff[0] == pulse_out_ff[1])
        else $error("outputs sharing a source differ");
    a_lin_binary: assert property (
        s_quiet ##0 ctrl_ff[1]
        && (sel_ff[0] inside {[8'h01:8'h0A]} || (sel_ff[0] == 8'h2F && ctrl_ff[4]))
        |-> lin_out_ff[0] == 10'h000 || lin_out_ff[0] == 10'h3E8)
        else $error("binary source not shown at full or zero scale");
    a_refuse_irq: assert property (
        ctrl_ff[0] && ien_ff[0] && wr_stb && addr[7:4] == 4'h2 |-> ##[1:3] irq_ff)
        else $error("refused selector write raised no interrupt");
    a_pulse_min: assert property (
        $fell(pulse_out_ff[2]) && sel_ff[2] == 8'h6F |-> run_len_ff >= TICK_CYC)
        else $error("pulse shorter than one resolution step");
    a_irq_masked: assert property (
        (ien_ff == 2'h0)[*3] |-> !irq_ff)
        else $error("interrupt high with all enables clear");
    a_rd_idle: assert property (
        !$past(rd_stb) |-> rdata_ff == 32'h0)
        else $error("read data outside its cycle");
endmodule // tpo_unit_chk

// ===== verification/tpo_heater_bank.sv
// Heater switches on the four outputs; counts ON cycles within a window.
`timescale 1ns/100ps
module tpo_heater_bank (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [3:0] drive,
    input wire logic       clr,
    input wire logic       win,
    output int             heat_cyc [4]
);
    // Switch wear is not modelled, so the short bench periods cost nothing here.
    always_ff @(posedge core_clk or negedge rst_n) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_n || clr) heat_cyc[i] <= 0;
            else if (win && drive[i]) heat_cyc[i] <= heat_cyc[i] + 1;
        end
    end
endmodule // tpo_heater_bank

// ===== verification/tpo_unit_tb.sv
// Self-checking testbench of the output unit.
`timescale 1ns/100ps
module tpo_unit_tb
    import tpo_pkg::*;
;
    localparam int TICK = 10;
    localparam int STEPS = 250;
    logic            core_clk = 1'b0;
    logic            rst_n = 1'b0;
    logic [7:0]      addr = 8'h00;
    logic [31:0]     wdata = 32'h0;
    logic            wr_stb = 1'b0;
    logic            rd_stb = 1'b0;
    logic [31:0]     rdata_ff;
    tpo_chan_t [3:0] ch_in = '0;
    logic [15:0]     dev_status = 16'h0000;
    logic [3:0]      pulse_out_ff;
    logic [1:0][9:0] lin_out_ff;
    logic            irq_ff;
    logic            win = 1'b0;
    logic            clr = 1'b0;
    int              heat_cyc [4];
    int              n_mismatch = 0;
    int              samples_checked = 0;
    logic [31:0]     seed = 32'h99602FF2;
    logic [31:0]     r;
    logic [31:0]     v;
    logic [15:0]     dp [4];
    int              vals [4];
    int              mw;

    always #2.5 core_clk = ~core_clk;

    tpo_unit #(.TICK_CYC(TICK)) u_tpo_unit (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff), .ch_in(ch_in),
        .dev_status(dev_status), .pulse_out_ff(pulse_out_ff), .lin_out_ff(lin_out_ff),
        .irq_ff(irq_ff));
    tpo_heater_bank u_tpo_heater_bank (.core_clk(core_clk), .rst_n(rst_n),
        .drive(pulse_out_ff), .clr(clr), .win(win), .heat_cyc(heat_cyc));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic int exp_on(input int val, input int w);
        int o;
        if (val < w) return 0;
        if (val >= 1000 - w) return STEPS;
        o = (STEPS * val + 500) / 1000;
        if (w > 0 && o < 1) o = 1;
        if (w > 0 && o > STEPS - 1) o = STEPS - 1;
        return o;
    endfunction

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, e, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask

    // Plain read: the data stand only in the cycle after the strobe, so look just after it.
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        v = rdata_ff;
    endtask

    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(what, e, v);
    endtask

    task automatic set_flags(input logic [31:0] f);
        @(posedge core_clk);
        for (int c = 0; c < 4; c++) ch_in[c][59:52] <= f[8*c+:8];
        cyc(6);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(4);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rc("sel", 8'h20 + 8'(4 * i), 32'(47 + 32 * i));
        rc("period", 8'h30, 32'h2);
        rc("minw", 8'h04, 32'h00A);
        rc("unmapped", 8'hF0, 32'h0);
        wr(8'h3C, 32'd120);
        rc("period clamp", 8'h3C, 32'h63);
        // Short periods keep the run brief; a relay load would want far longer ones.
        for (int i = 0; i < 4; i++) wr(8'h30 + 8'(4 * i), 32'h0);
        $display("registers done");
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 4; j++) if (j != 2) wr(8'h20 + 8'(4 * j), 32'(2 + k));
            for (int p = 0; p < 4; p++) begin
                seed = xs(seed);
                r = (p == 0) ? seed : (p == 1) ? 32'h0 : (p == 2) ? '1 : ~(32'h1 << seed[4:0]);
                set_flags(r);
                for (int j = 0; j < 4; j++) begin
                    if (j != 2) begin
                        v = 32'((k == 0) ? |r : &r);
                        chk("shared", v, 32'(pulse_out_ff[j]));
                    end
                end
            end
        end
        $display("routing done");
        wr(8'h10, 32'h3);
        wr(8'h2C, 32'h1);
        seed = xs(seed);
        dp = '{16'h0000, 16'hC000, 16'h2000, seed[15:0] | 16'h0001};
        for (int p = 0; p < 4; p++) begin
            dev_status <= dp[p];
            cyc(7);
            chk("error source", 32'(|dp[p][13:0]), 32'(pulse_out_ff[3]));
        end
        chk("error irq", 32'h1, 32'(irq_ff));
        rc("status", 8'h08, 32'h2);
        wr(8'h0C, 32'h3);
        dev_status <= 16'h0000;
        cyc(4);
        chk("irq cleared", 32'h0, 32'(irq_ff));
        wr(8'h10, 32'h0);
        dev_status <= 16'h0004;
        cyc(7);
        chk("masked irq", 32'h0, 32'(irq_ff));
        rc("masked status", 8'h08, 32'h2);
        wr(8'h0C, 32'h3);
        dev_status <= 16'h0000;
        $display("error source done");
        wr(8'h00, 32'h2);
        wr(8'h20, 32'h2);
        set_flags(32'h0000_0100);
        chk("linear on", 32'h3E8, 32'(lin_out_ff[0]));
        chk("linear two off", 32'h0, 32'(lin_out_ff[1]));
        set_flags(32'hFFFF_FFFF);
        chk("linear two on", 32'h3E8, 32'(lin_out_ff[1]));
        set_flags(32'h0);
        chk("linear off", 32'h0, 32'(lin_out_ff[0]));
        wr(8'h20, 32'd26);
        ch_in[0].process_value <= 16'd640;
        cyc(7);
        chk("linear pv", 32'd640, 32'(lin_out_ff[0]));
        wr(8'h20, 32'h2F);
        ch_in[0].manip_heat <= 10'd357;
        cyc(7);
        chk("linear value", 32'd357, 32'(lin_out_ff[0]));
        wr(8'h00, 32'h12);
        cyc(7);
        chk("linear onoff", 32'h3E8, 32'(lin_out_ff[0]));
        $display("linear done");
        wr(8'h00, 32'h1);
        wr(8'h10, 32'h1);
        wr(8'h20, 32'h5);
        wr(8'h30, 32'h9);
        wr(8'h04, 32'h64);
        rc("sel kept", 8'h20, 32'h2F);
        rc("period kept", 8'h30, 32'h0);
        rc("minw kept", 8'h04, 32'h00A);
        chk("refused irq", 32'h1, 32'(irq_ff));
        rc("refused status", 8'h08, 32'h1);
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h0);
        $display("refusal done");
        ch_in[0].process_value <= 16'd1234;
        cyc(1100);
        rc("filter bypass", 8'h50, 32'd1234);
        wr(8'h40, 32'h1);
        // Let the gain divider catch up with the new time constant before the step.
        cyc(100);
        ch_in[0].process_value <= 16'd0;
        for (int n = 0; n < 400 && v == 32'd1234; n++) rd(8'h50);
        rc("filter step", 8'h50, 32'd617);
        chk("filter partial", 32'h1, 32'(v > 0 && v < 1234));
        $display("filter done");
        // Each output follows the heating value of its own channel.
        for (int j = 0; j < 4; j++) wr(8'h20 + 8'(4 * j), 32'(47 + 32 * j));
        for (int k = 0; k < 2; k++) begin
            mw = (k == 0) ? 100 : 1;
            if (k == 0) vals = '{50, 900, 899, 333};
            else vals = '{1, 999, 998, 500};
            wr(8'h04, 32'(mw));
            for (int c = 0; c < 4; c++) ch_in[c].manip_heat <= 10'(vals[c]);
            cyc((k == 0 ? 10000 : 0) + 2 * STEPS * TICK + 20);
            clr <= 1'b1;
            cyc(1);
            clr <= 1'b0;
            win <= 1'b1;
            cyc(STEPS * TICK);
            win <= 1'b0;
            cyc(2);
            for (int c = 0; c < 4; c++) begin
                v = 32'(exp_on(vals[c], mw) * TICK);
                chk("on cycles", v, 32'(heat_cyc[c]));
            end
        end
        $display("pulse done");
        complete_run();
    end

    initial begin
        cyc(60000);
        n_mismatch++;
        complete_run();
    end
endmodule // tpo_unit_tb

bind tpo_unit tpo_unit_chk #(.TICK_CYC(TICK_CYC)) u_tpo_unit_chk (.core_clk(core_clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata_ff(rdata_ff), .ch_in(ch_in), .dev_status(dev_status),
    .pulse_out_ff(pulse_out_ff), .lin_out_ff(lin_out_ff), .irq_ff(irq_ff));
